// ===== rtl/imw_defs.vh
// Constants for the idle-mode and pin-wakeup controller.
// Assumes a single 20 MHz clock and a plain address/strobe register port.
`ifndef IMW_DEFS_VH
`define IMW_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IMW_ADDR_WAKE_ENABLE   4'h0
`define IMW_ADDR_WAKE_EDGE     4'h1
`define IMW_ADDR_WAKE_PENDING  4'h2
`define IMW_ADDR_POWER_CTRL    4'h3
`define IMW_ADDR_TIMER_CTRL    4'h4
`define IMW_ADDR_IRQ_STATUS    4'h5
`define IMW_ADDR_IRQ_CLEAR     4'h6
`define IMW_ADDR_IRQ_ENABLE    4'h7
`define IMW_ADDR_STATE         4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IMW_PWR_IDLE_BIT       0
`define IMW_PWR_HALT_BIT       1
`define IMW_TMR_PEND_BIT       0
`define IMW_TMR_IRQEN_BIT      1
`define IMW_IRQ_WAKE_BIT       0
`define IMW_IRQ_TIMER_BIT      1
`define IMW_IRQ_REFUSED_BIT    2
`define IMW_IRQ_WIDTH          3

// ----------------------------------------
// Timing and reset values
// ----------------------------------------
`define IMW_TIMER_WIDTH        13
`define IMW_TIMER_TAP          12
`define IMW_RESET_BYTE         8'h00
`define IMW_RESET_IRQ          3'h0

// ----------------------------------------
// Power states
// ----------------------------------------
`define IMW_ST_RUN             2'h0
`define IMW_ST_IDLE            2'h1
`define IMW_ST_HALT            2'h2

`endif

// ===== rtl/imw_idle_wakeup.v
// Idle/halt power-mode control with eight-pin multi-input wakeup.
// Assumes wakeup pins are asynchronous inputs; the CPU reads run_out.
//
// Overview of operation
// - Idle flag write enters idle; timer runs.
// - Reset or pin wakeup leaves idle mode.
// - Timer bit twelve toggle ends idle.
// - Each bit twelve toggle sets pending flag.
// - Timer interrupt only while its enable set.
// - Enabled timer interrupt serviced, then resume.
// - Disabled timer interrupt: resume directly after idle.
// - Wakeup pins wake or interrupt, per-edge.
// - Wake enable register, one bit per pin.
// - Edge select: one falling, zero rising.
// - Selected edge sets sticky pending bit.
// - Halt refused while enabled pending bit exists.
// - Reset clears enable and edge registers.
// - Pin wakeup resumes; reset restarts at zero.
// - Halt-disable option keeps halt flag zero.
//
// Local design decisions: strobed register access and the placing of the registers.
module imw_idle_wakeup #(
  parameter PINS = 8
) (
  input  wire            clock_in,
  input  wire            srst_in,
  input  wire [3:0]      addr_in,
  input  wire [7:0]      wdata_in,
  input  wire            wr_in,
  input  wire            rd_in,
  input  wire            halt_disable_in,
  input  wire [PINS-1:0] wake_pins_in,
  output reg  [7:0]      rdata_out,
  output wire            run_out,
  output wire            restart_out,
  output wire            timer_irq_out,
  output wire            wake_irq_out,
  output wire            irq_out
);
`include "imw_defs.vh"

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [PINS-1:0]             wake_enable_reg;
  reg [PINS-1:0]             wake_edge_select_reg;
  reg [PINS-1:0]             wake_pending_reg;
  reg [PINS-1:0]             sync1_reg;
  reg [PINS-1:0]             sync2_reg;
  reg [PINS-1:0]             prev_reg;
  reg [`IMW_TIMER_WIDTH-1:0] idle_interval_timer_reg;
  reg                        tap_prev_reg;
  reg                        idle_timer_pending_flag_reg;
  reg                        idle_timer_irq_enable_reg;
  reg [1:0]                  state_reg;
  reg [1:0]                  state_next;
  reg [`IMW_IRQ_WIDTH-1:0]   irq_status_reg;
  reg [`IMW_IRQ_WIDTH-1:0]   irq_enable_reg;
  reg                        restart_reg;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function wr_hit;
    input [3:0] a;
    begin
      wr_hit = wr_in && (addr_in == a);
    end
  endfunction

  // Edge qualifiers from synchronised samples
  wire [PINS-1:0] rise_w   = sync2_reg & ~prev_reg;
  wire [PINS-1:0] fall_w   = ~sync2_reg & prev_reg;
  wire [PINS-1:0] hit_w    = (wake_edge_select_reg & fall_w) |
                             (~wake_edge_select_reg & rise_w);
  wire            wake_w   = |(wake_enable_reg & wake_pending_reg);
  wire            toggle_w = idle_interval_timer_reg[`IMW_TIMER_TAP] != tap_prev_reg;
  // Written out in full so the nets follow wr_in and addr_in directly
  wire            pwr_hit_w  = wr_in && (addr_in == `IMW_ADDR_POWER_CTRL);
  wire            idle_req_w = pwr_hit_w && wdata_in[`IMW_PWR_IDLE_BIT];
  wire            halt_req_w = pwr_hit_w && wdata_in[`IMW_PWR_HALT_BIT];
  // A halt request that the pending check or the option blocks
  wire            halt_refused_w = halt_req_w && (halt_disable_in || wake_w);

  // ----------------------------------------
  // Pin synchroniser and edge capture
  // ----------------------------------------
  // First stage is read only by the second, to contain metastability
  always @(posedge clock_in) begin
    sync1_reg <= wake_pins_in;
    sync2_reg <= sync1_reg;
    prev_reg  <= sync2_reg;
  end

  // ----------------------------------------
  // Wakeup registers
  // ----------------------------------------
  // Pending has no reset: it holds whatever it powers up with.
  // Hardware set wins over a software clear in the same cycle.
  always @(posedge clock_in) begin
    if (wr_hit(`IMW_ADDR_WAKE_PENDING)) begin
      wake_pending_reg <= wdata_in[PINS-1:0] | hit_w;
    end else begin
      wake_pending_reg <= wake_pending_reg | hit_w;
    end
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      wake_enable_reg      <= {PINS{1'b0}};
      wake_edge_select_reg <= {PINS{1'b0}};
    end else begin
      if (wr_hit(`IMW_ADDR_WAKE_ENABLE)) begin
        wake_enable_reg <= wdata_in[PINS-1:0];
      end
      if (wr_hit(`IMW_ADDR_WAKE_EDGE)) begin
        wake_edge_select_reg <= wdata_in[PINS-1:0];
      end
    end
  end

  // ----------------------------------------
  // Idle timer
  // ----------------------------------------
  // Free running; bit twelve toggles every 4096 cycles
  always @(posedge clock_in) begin
    if (srst_in) begin
      idle_interval_timer_reg     <= {`IMW_TIMER_WIDTH{1'b0}};
      tap_prev_reg                <= 1'b0;
      idle_timer_pending_flag_reg <= 1'b0;
      idle_timer_irq_enable_reg   <= 1'b0;
    end else begin
      idle_interval_timer_reg <= idle_interval_timer_reg + 1'b1;
      tap_prev_reg            <= idle_interval_timer_reg[`IMW_TIMER_TAP];
      if (toggle_w) begin
        idle_timer_pending_flag_reg <= 1'b1;
      end else if (wr_hit(`IMW_ADDR_TIMER_CTRL)) begin
        idle_timer_pending_flag_reg <= wdata_in[`IMW_TMR_PEND_BIT];
      end
      if (wr_hit(`IMW_ADDR_TIMER_CTRL)) begin
        idle_timer_irq_enable_reg <= wdata_in[`IMW_TMR_IRQEN_BIT];
      end
    end
  end

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `IMW_ST_RUN: begin
        if (halt_req_w && !halt_refused_w) begin
          state_next = `IMW_ST_HALT;
        end else if (idle_req_w) begin
          state_next = `IMW_ST_IDLE;
        end
      end
      `IMW_ST_IDLE: begin
        // Timer exit resumes inline; interrupt service is gated by enable
        if (wake_w || toggle_w) begin
          state_next = `IMW_ST_RUN;
        end
      end
      `IMW_ST_HALT: begin
        if (wake_w) begin
          state_next = `IMW_ST_RUN;
        end
      end
      default: begin
        state_next = `IMW_ST_RUN;
      end
    endcase
  end

  always @(posedge clock_in) begin
    if (srst_in) begin
      state_reg   <= `IMW_ST_RUN;
      restart_reg <= 1'b1;
    end else begin
      state_reg   <= state_next;
      restart_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------
  wire [`IMW_IRQ_WIDTH-1:0] ev_w = {halt_refused_w, toggle_w, |hit_w};

  always @(posedge clock_in) begin
    if (srst_in) begin
      irq_status_reg <= `IMW_RESET_IRQ;
      irq_enable_reg <= `IMW_RESET_IRQ;
    end else begin
      if (wr_hit(`IMW_ADDR_IRQ_CLEAR)) begin
        irq_status_reg <= (irq_status_reg & ~wdata_in[`IMW_IRQ_WIDTH-1:0]) | ev_w;
      end else begin
        irq_status_reg <= irq_status_reg | ev_w;
      end
      if (wr_hit(`IMW_ADDR_IRQ_ENABLE)) begin
        irq_enable_reg <= wdata_in[`IMW_IRQ_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped and write-only addresses read as zero
  always @(posedge clock_in) begin
    if (srst_in) begin
      rdata_out <= `IMW_RESET_BYTE;
    end else if (rd_in) begin
      case (addr_in)
        `IMW_ADDR_WAKE_ENABLE:  rdata_out <= wake_enable_reg;
        `IMW_ADDR_WAKE_EDGE:    rdata_out <= wake_edge_select_reg;
        `IMW_ADDR_WAKE_PENDING: rdata_out <= wake_pending_reg;
        `IMW_ADDR_POWER_CTRL:   rdata_out <= {6'h00, state_reg == `IMW_ST_HALT,
                                              state_reg == `IMW_ST_IDLE};
        `IMW_ADDR_TIMER_CTRL:   rdata_out <= {6'h00, idle_timer_irq_enable_reg,
                                              idle_timer_pending_flag_reg};
        `IMW_ADDR_IRQ_STATUS:   rdata_out <= {5'h00, irq_status_reg};
        `IMW_ADDR_IRQ_ENABLE:   rdata_out <= {5'h00, irq_enable_reg};
        `IMW_ADDR_STATE:        rdata_out <= {6'h00, state_reg};
        default:                rdata_out <= `IMW_RESET_BYTE;
      endcase
    end else begin
      rdata_out <= `IMW_RESET_BYTE;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign run_out       = state_reg == `IMW_ST_RUN;
  assign restart_out   = restart_reg;
  assign timer_irq_out = idle_timer_pending_flag_reg & idle_timer_irq_enable_reg;
  assign wake_irq_out  = wake_w;
  assign irq_out       = |(irq_status_reg & irq_enable_reg);

endmodule

// ===== sim/imw_assertions.sv
// Port-level checker for the idle and pin wakeup controller.
// Assumes one clock domain; bound to every instance of the top module.
`include "imw_defs.vh"
module imw_assertions #(parameter PINS = 8) (
  input wire logic            clock_in,
  input wire logic            srst_in,
  input wire logic [3:0]      addr_in,
  input wire logic [7:0]      wdata_in,
  input wire logic            wr_in,
  input wire logic            rd_in,
  input wire logic            halt_disable_in,
  input wire logic [PINS-1:0] wake_pins_in,
  input wire logic [7:0]      rdata_out,
  input wire logic            run_out,
  input wire logic            restart_out,
  input wire logic            timer_irq_out,
  input wire logic            wake_irq_out,
  input wire logic            irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  // Power control write; entry checks hinge on it
  wire pw = wr_in && addr_in == `IMW_ADDR_POWER_CTRL;
  a_read_quiet: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside slot");
  a_restart_once: assert property ($past(srst_in) |-> restart_out ##1 !restart_out)
    else $error("restart pulse wrong");
  a_halt_refused: assert property (run_out && wake_irq_out && pw && wdata_in == 8'h02 |=> run_out)
    else $error("halt taken while wake pending");
  a_halt_off: assert property (run_out && halt_disable_in && pw && wdata_in == 8'h02 |=> run_out)
    else $error("halt taken while disabled");
  a_idle_entry: assert property (run_out && !wake_irq_out && pw && wdata_in == 8'h01 |=> !run_out)
    else $error("idle not entered");
  a_wake_exit: assert property (!run_out && wake_irq_out |-> ##[0:2] run_out)
    else $error("pin wakeup ignored");
  a_wake_sticky: assert property (wake_irq_out && !wr_in |=> wake_irq_out)
    else $error("wake pending lost");
  a_timer_sticky: assert property (timer_irq_out && !wr_in |=> timer_irq_out)
    else $error("timer pending lost");
  c_idle: cover property (pw ##1 !run_out);
  c_timer: cover property ($rose(timer_irq_out));
  c_wake: cover property ($rose(wake_irq_out));
endmodule
bind imw_idle_wakeup imw_assertions #(.PINS(PINS)) u_chk (.clock_in(clock_in),
  .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .halt_disable_in(halt_disable_in), .wake_pins_in(wake_pins_in), .rdata_out(rdata_out),
  .run_out(run_out), .restart_out(restart_out), .timer_irq_out(timer_irq_out),
  .wake_irq_out(wake_irq_out), .irq_out(irq_out));

// ===== sim/imw_pin_model.sv
// Far-side model of the eight external wakeup pins.
// Assumes the bench sets the wanted levels; the pins have no pulls.
module imw_pin_model (
  input  wire logic       clock_in,
  input  wire logic [7:0] level_in,
  output logic      [7:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Levels move 17 ns after the edge, so the block must resync them
  initial pins_out = 8'h00;
  always @(posedge clock_in) pins_out <= #17 level_in;
endmodule

// ===== sim/tb.sv
// Self-checking bench for the idle and pin wakeup controller.
// Assumes the pin model drives the wakeup port; one 20 MHz clock.
`include "imw_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] EN = `IMW_ADDR_WAKE_ENABLE, ED = `IMW_ADDR_WAKE_EDGE;
  localparam logic [3:0] PD = `IMW_ADDR_WAKE_PENDING, PW = `IMW_ADDR_POWER_CTRL;
  localparam logic [3:0] TM = `IMW_ADDR_TIMER_CTRL, ST = `IMW_ADDR_IRQ_STATUS;
  localparam logic [3:0] CL = `IMW_ADDR_IRQ_CLEAR, IE = `IMW_ADDR_IRQ_ENABLE;
  logic       clock_in = 1'b0, srst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
  logic       halt_disable_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00, lvl = 8'h00, pins, rdata_out;
  logic       run_out, restart_out, timer_irq_out, wake_irq_out, irq_out;
  int         fails = 0, compares = 0;
  // Half period of 25 ns gives 20 MHz
  always #25 clock_in = ~clock_in;
  imw_idle_wakeup u_dut (.clock_in(clock_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .halt_disable_in(halt_disable_in),
    .wake_pins_in(pins), .rdata_out(rdata_out), .run_out(run_out),
    .restart_out(restart_out), .timer_irq_out(timer_irq_out),
    .wake_irq_out(wake_irq_out), .irq_out(irq_out));
  imw_pin_model u_pins (.clock_in(clock_in), .level_in(lvl), .pins_out(pins));
  task chk(input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task fc(input logic f, e);
    chk({7'h00, f}, {7'h00, e});
  endtask
  // Strobe drops at the taking edge; next call waits an edge first
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(negedge clock_in);
  endtask
  task rc(input logic [3:0] a, input logic [7:0] m, e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    chk(rdata_out & m, e);
  endtask
  // Sync chain plus model delay need about four edges
  task pin(input logic [7:0] l);
    @(posedge clock_in);
    lvl <= l;
    repeat (9) @(negedge clock_in);
  endtask
  task tally_and_finish;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task t_reset;
    repeat (12) @(posedge clock_in);
    srst_in <= 1'b0;
    @(negedge clock_in);
    fc(restart_out, 1'b1);
    @(negedge clock_in);
    fc(restart_out, 1'b0);
    rc(EN, 8'hff, `IMW_RESET_BYTE);
    rc(ED, 8'hff, `IMW_RESET_BYTE);
    $display("test reset done");
  endtask
  task t_pins;
    wr(ED, 8'h0f);
    wr(PD, 8'h00);
    wr(EN, 8'hff);
    rc(ED, 8'hff, 8'h0f);
    rc(4'h9, 8'hff, 8'h00);
    pin(8'hff);
    rc(PD, 8'hff, 8'hf0);
    pin(8'h00);
    rc(PD, 8'hff, 8'hff);
    wr(IE, 8'h01);
    fc(irq_out, 1'b1);
    wr(IE, 8'h00);
    fc(irq_out, 1'b0);
    wr(CL, 8'h01);
    rc(ST, 8'h01, 8'h00);
    $display("test pins done");
  endtask
  task t_halt;
    wr(PW, 8'h02);
    fc(run_out, 1'b1);
    rc(ST, 8'h04, 8'h04);
    @(posedge clock_in);
    halt_disable_in <= 1'b1;
    wr(PD, 8'h00);
    wr(PW, 8'h02);
    rc(PW, 8'h02, 8'h00);
    @(posedge clock_in);
    halt_disable_in <= 1'b0;
    wr(PW, 8'h02);
    fc(run_out, 1'b0);
    pin(8'hff);
    fc(run_out, 1'b1);
    wr(EN, 8'h00);
    wr(ED, 8'hff);
    wr(PD, 8'h00);
    wr(EN, 8'hff);
    fc(wake_irq_out, 1'b0);
    pin(8'h00);
    rc(PD, 8'hff, 8'hff);
    $display("test halt done");
  endtask
  task t_idle;
    wr(EN, 8'h00);
    wr(TM, 8'h02);
    wr(PW, 8'h01);
    fc(run_out, 1'b0);
    repeat (2) @(posedge clock_in);
    for (int i = 0; i < 4200 && run_out !== 1'b1; i++) @(negedge clock_in);
    fc(run_out, 1'b1);
    fc(timer_irq_out, 1'b1);
    wr(TM, 8'h00);
    fc(timer_irq_out, 1'b0);
    wr(PW, 8'h01);
    for (int i = 0; i < 4200 && run_out !== 1'b1; i++) @(negedge clock_in);
    fc(run_out, 1'b1);
    rc(TM, 8'h03, 8'h01);
    $display("test idle done");
  endtask
  initial begin
    t_reset;
    t_pins;
    t_halt;
    t_idle;
    tally_and_finish;
  end
  // Tests need about 8200 cycles; 20000 leaves margin
  initial begin
    #1000000;
    fails++;
    tally_and_finish;
  end
endmodule
